// *** verilog/shad_pkg.sv ***
// Shared types and constants of the shift and add datapath
package shad_pkg;

  // ==========================================================
  // Widths
  localparam int SHAD_DATA_W = 32;
  localparam int SHAD_AMT_W  = 8;
  localparam int SHAD_BYTE_W = 8;
  localparam int SHAD_HALF_W = 16;
  localparam int SHAD_SAT_W  = 6;

  // ==========================================================
  // Reset value of the operation code; the datapath has no register that loads it
  localparam logic [3:0] SHAD_OP_RST = 4'h0;

  // ==========================================================
  // Operation select
  typedef enum logic [3:0] {
    OP_LOGICAL_SHIFT_LEFT    = 4'h0,
    OP_LOGICAL_SHIFT_RIGHT   = 4'h1,
    OP_ARITHMETIC_SHIFT_RIGHT = 4'h2,
    OP_ROTATE_RIGHT          = 4'h3,
    OP_ROTATE_THROUGH_CARRY  = 4'h4,
    OP_ADD                   = 4'h5,
    OP_SUB                   = 4'h6,
    OP_ADD_PAIR              = 4'h7,
    OP_SUB_PAIR              = 4'h8,
    OP_LOAD_EXTEND           = 4'h9,
    OP_SAT_SIGNED            = 4'ha,
    OP_SAT_UNSIGNED          = 4'hb
  } shad_op_e;

  // Shift kinds seen by the shifter
  typedef enum logic [2:0] {
    SH_LEFT   = 3'h0,
    SH_RIGHT  = 3'h1,
    SH_ARITH  = 3'h2,
    SH_ROTATE = 3'h3,
    SH_EXTEND = 3'h4
  } shad_shift_e;

  // Loaded data size
  typedef enum logic [1:0] {
    SIZE_BYTE = 2'h0,
    SIZE_HALF = 2'h1,
    SIZE_WORD = 2'h2
  } shad_size_e;

  // ==========================================================
  // Request from execute control
  typedef struct packed {
    shad_op_e               op;
    logic [SHAD_DATA_W-1:0] opa;
    logic [SHAD_DATA_W-1:0] opb;
    logic [SHAD_DATA_W-1:0] opa_hi;
    logic [SHAD_DATA_W-1:0] opb_hi;
    logic [SHAD_AMT_W-1:0]  amount;
    logic                   carry_in;
    shad_size_e             load_size;
    logic                   load_signed;
  } shad_req_s;

  // Answer to execute control
  typedef struct packed {
    logic [SHAD_DATA_W-1:0] result;
    logic [SHAD_DATA_W-1:0] result_hi;
    logic                   carry;
    logic                   overflow;
    logic                   saturated;
  } shad_rsp_s;

  // One adder pass
  typedef struct packed {
    logic [SHAD_DATA_W-1:0] sum;
    logic                   carry;
    logic                   overflow;
  } shad_sum_s;

endpackage : shad_pkg

// *** verilog/shad_shifter.sv ***
// Barrel shifter with carry output for five shift kinds
`timescale 1ns/1ps
module shad_shifter
  import shad_pkg::*;
#(
  parameter int WIDTH = SHAD_DATA_W,
  parameter int AMT_W = SHAD_AMT_W
) (
  // Operation
  input  wire shad_shift_e      kind_i,
  input  wire logic [AMT_W-1:0] amount_i,
  input  wire logic             carry_in_i,
  input  wire logic [WIDTH-1:0] value_i,
  // Answer
  output logic      [WIDTH-1:0] result_o,
  output logic                  carry_o
);

  localparam int CW = $clog2(WIDTH + 2);
  localparam logic [CW-1:0] SAT_AMT = CW'(WIDTH + 1);

  if (WIDTH < 2 || (1 << AMT_W) <= WIDTH) begin : g_chk
    $error("shad_shifter: unsupported width or amount width");
  end

  logic [CW-1:0]          amt_c;
  logic [WIDTH:0]         ext;
  logic signed [WIDTH:0]  sext;
  logic [2*WIDTH-1:0]     rot;

  always_comb begin
    // Amounts past the width behave like width plus one
    if (amount_i > AMT_W'(SAT_AMT)) begin
      amt_c = SAT_AMT;
    end else begin
      amt_c = amount_i[CW-1:0];
    end
    result_o = value_i;
    carry_o  = carry_in_i;
    ext      = '0;
    sext     = '0;
    rot      = '0;
    case (kind_i)
      SH_LEFT: begin
        ext = {1'b0, value_i} << amt_c;
        if (amt_c != '0) begin
          result_o = ext[WIDTH-1:0];
          carry_o  = ext[WIDTH];
        end
      end
      SH_RIGHT: begin
        ext = {value_i, 1'b0} >> amt_c;
        if (amt_c != '0) begin
          result_o = ext[WIDTH:1];
          carry_o  = ext[0];
        end
      end
      SH_ARITH: begin
        sext = $signed({value_i, 1'b0}) >>> amt_c;
        if (amt_c != '0) begin
          result_o = sext[WIDTH:1];
          carry_o  = sext[0];
        end
      end
      SH_ROTATE: begin
        rot = {value_i, value_i} >> (amount_i % AMT_W'(WIDTH));
        if (amount_i != '0) begin
          result_o = rot[WIDTH-1:0];
          carry_o  = rot[WIDTH-1];
        end
      end
      SH_EXTEND: begin
        result_o = {carry_in_i, value_i[WIDTH-1:1]};
        carry_o  = value_i[0];
      end
      default: begin
        result_o = value_i;
        carry_o  = carry_in_i;
      end
    endcase
  end

endmodule : shad_shifter

// *** verilog/shad_datapath.sv ***
// Integer shift, add and load-extend datapath of the execute stage
`timescale 1ns/1ps

// Contract
// - Register operands 32 bits; loads 8/16/32
// - Narrow loads zero- or sign-extend as selected
// - Unsigned values read as plain binary
// - Signed values read as two's complement
// - 64-bit values travel as register pairs
// - Left shift fills zeros, top bit carries
// - Right shift fills zeros, bottom bit carries
// - Arithmetic right shift copies sign bit
// - Rotate modulo width, carry is result MSB
// - Carry rotate: one step, carry in top
// - Zero amount returns operand unchanged
// - Adder: equal widths, carry in, low result
// - Carry out when unsigned sum overflows
// - Overflow when signed sum misfits result
// - Invert y, carry one: x-y, no borrow
// - Invert y, carry zero: x-y-1, x>y carry
// - Saturation clamps and reports clamping
module shad_datapath
  import shad_pkg::*;
(
  // Clock and reset
  input  wire logic      clk_sys_i,
  input  wire logic      reset_i,
  // Request from execute control
  input  wire shad_req_s req_i,
  // Answer
  output shad_rsp_s      rsp_o
);

  localparam int DW = SHAD_DATA_W;

  if (DW != 32 || SHAD_BYTE_W >= SHAD_HALF_W) begin : g_chk
    $error("shad_datapath: unsupported data width");
  end

  // ==========================================================
  // Helper functions
  function automatic shad_sum_s carry_adder(
    input logic [DW-1:0] x,
    input logic [DW-1:0] y,
    input logic          cin
  );
    logic [DW:0] u;
    shad_sum_s   r;
    u = {1'b0, x} + {1'b0, y} + {{DW{1'b0}}, cin};
    r.sum = u[DW-1:0];
    r.carry = u[DW];
    r.overflow = (x[DW-1] == y[DW-1]) && (r.sum[DW-1] != x[DW-1]);
    return r;
  endfunction : carry_adder

  function automatic logic [DW-1:0] load_extend(
    input logic [DW-1:0] x,
    input shad_size_e    size,
    input logic          sgn
  );
    logic [DW-1:0] r;
    r = x;
    case (size)
      SIZE_BYTE: r = {{(DW-SHAD_BYTE_W){sgn & x[SHAD_BYTE_W-1]}},
                      x[SHAD_BYTE_W-1:0]};
      SIZE_HALF: r = {{(DW-SHAD_HALF_W){sgn & x[SHAD_HALF_W-1]}},
                      x[SHAD_HALF_W-1:0]};
      default:   r = x;
    endcase
    return r;
  endfunction : load_extend

  // ==========================================================
  // Shifter
  shad_shift_e   sh_kind;
  logic [DW-1:0] sh_result;
  logic          sh_carry;

  always_comb begin
    case (req_i.op)
      OP_LOGICAL_SHIFT_LEFT:     sh_kind = SH_LEFT;
      OP_LOGICAL_SHIFT_RIGHT:    sh_kind = SH_RIGHT;
      OP_ARITHMETIC_SHIFT_RIGHT: sh_kind = SH_ARITH;
      OP_ROTATE_RIGHT:           sh_kind = SH_ROTATE;
      default:                   sh_kind = SH_EXTEND;
    endcase
  end

  shad_shifter #(
    .WIDTH (DW),
    .AMT_W (SHAD_AMT_W)
  ) u_shifter (
    .kind_i     (sh_kind),
    .amount_i   (req_i.amount),
    .carry_in_i (req_i.carry_in),
    .value_i    (req_i.opa),
    .result_o   (sh_result),
    .carry_o    (sh_carry)
  );

  // ==========================================================
  // Adder, pair adder, saturation
  logic          invert;
  shad_sum_s     add_lo;
  shad_sum_s     add_hi;
  logic [5:0]    sat_n;
  logic signed [DW+1:0] sat_in;
  logic signed [DW+1:0] sat_max;
  logic signed [DW+1:0] sat_min;
  logic signed [DW+1:0] sat_val;
  logic          sat_hit;

  always_comb begin
    invert = (req_i.op == OP_SUB) || (req_i.op == OP_SUB_PAIR);
    add_lo = carry_adder(req_i.opa, invert ? ~req_i.opb : req_i.opb,
                         req_i.carry_in);
    add_hi = carry_adder(req_i.opa_hi,
                         invert ? ~req_i.opb_hi : req_i.opb_hi,
                         add_lo.carry);
  end

  always_comb begin
    // Width 0 or above the register width means full width
    if (req_i.amount == '0 || req_i.amount > SHAD_AMT_W'(DW)) begin
      sat_n = 6'(DW);
    end else begin
      sat_n = req_i.amount[SHAD_SAT_W-1:0];
    end
    sat_in = (DW+2)'($signed(req_i.opa));
    if (req_i.op == OP_SAT_UNSIGNED) begin
      sat_max = ((DW+2)'(1) <<< sat_n) - (DW+2)'(1);
      sat_min = '0;
    end else begin
      sat_max = ((DW+2)'(1) <<< (sat_n - 6'h1)) - (DW+2)'(1);
      sat_min = -((DW+2)'(1) <<< (sat_n - 6'h1));
    end
    sat_hit = 1'b1;
    if (sat_in > sat_max) begin
      sat_val = sat_max;
    end else if (sat_in < sat_min) begin
      sat_val = sat_min;
    end else begin
      sat_val = sat_in;
      sat_hit = 1'b0;
    end
  end

  // ==========================================================
  // Answer select, same cycle as the request
  always_comb begin
    rsp_o           = '0;
    rsp_o.carry     = req_i.carry_in;
    case (req_i.op)
      OP_LOGICAL_SHIFT_LEFT,
      OP_LOGICAL_SHIFT_RIGHT,
      OP_ARITHMETIC_SHIFT_RIGHT,
      OP_ROTATE_RIGHT,
      OP_ROTATE_THROUGH_CARRY: begin
        rsp_o.result = sh_result;
        rsp_o.carry  = sh_carry;
      end
      OP_ADD, OP_SUB: begin
        rsp_o.result   = add_lo.sum;
        rsp_o.carry    = add_lo.carry;
        rsp_o.overflow = add_lo.overflow;
      end
      OP_ADD_PAIR, OP_SUB_PAIR: begin
        rsp_o.result    = add_lo.sum;
        rsp_o.result_hi = add_hi.sum;
        rsp_o.carry     = add_hi.carry;
        rsp_o.overflow  = add_hi.overflow;
      end
      OP_LOAD_EXTEND: begin
        rsp_o.result = load_extend(req_i.opa, req_i.load_size,
                                   req_i.load_signed);
      end
      OP_SAT_SIGNED, OP_SAT_UNSIGNED: begin
        rsp_o.result    = sat_val[DW-1:0];
        rsp_o.saturated = sat_hit;
      end
      default: begin
        rsp_o.result = req_i.opa;
      end
    endcase
  end

  // ==========================================================
  // Checks
  default clocking cb @(posedge clk_sys_i); endclocking
  default disable iff (reset_i);

  shad_op_e op;
  logic [DW-1:0] a;
  logic [DW-1:0] b;
  logic [SHAD_AMT_W-1:0] n;
  assign op = req_i.op;
  assign a  = req_i.opa;
  assign b  = req_i.opb;
  assign n  = req_i.amount;

  property p_load_word;
    op == OP_LOAD_EXTEND && req_i.load_size == SIZE_WORD
      |-> rsp_o.result == a;
  endproperty
  a_load_word: assert property (p_load_word)
    else $error("word load altered data");

  property p_load_ext;
    op == OP_LOAD_EXTEND && req_i.load_size == SIZE_BYTE
      |-> rsp_o.result == {{24{req_i.load_signed & a[7]}}, a[7:0]};
  endproperty
  a_load_ext: assert property (p_load_ext)
    else $error("byte load extended wrongly");

  property p_pair;
    op == OP_ADD_PAIR |-> {rsp_o.carry, rsp_o.result_hi, rsp_o.result}
      == {1'b0, req_i.opa_hi, a} + {1'b0, req_i.opb_hi, b}
       + 65'(req_i.carry_in);
  endproperty
  a_pair: assert property (p_pair)
    else $error("pair add wrong");

  property p_shl;
    op == OP_LOGICAL_SHIFT_LEFT && n > 0 && n < 32
      |-> rsp_o.result == a << n && rsp_o.carry == a[32 - n];
  endproperty
  a_shl: assert property (p_shl)
    else $error("left shift wrong");

  property p_shr;
    op == OP_LOGICAL_SHIFT_RIGHT && n > 0 && n < 33
      |-> rsp_o.result == a >> n && rsp_o.carry == a[n - 1];
  endproperty
  a_shr: assert property (p_shr)
    else $error("right shift wrong");

  property p_asr;
    op == OP_ARITHMETIC_SHIFT_RIGHT && n > 31
      |-> rsp_o.result == {32{a[31]}} && rsp_o.carry == a[31];
  endproperty
  a_asr: assert property (p_asr)
    else $error("arithmetic shift lost sign");

  property p_ror;
    op == OP_ROTATE_RIGHT && n != 0
      |-> rsp_o.carry == rsp_o.result[31]
       && rsp_o.result == 32'({a, a} >> n[4:0]);
  endproperty
  a_ror: assert property (p_ror)
    else $error("rotate wrong");

  property p_rrx;
    op == OP_ROTATE_THROUGH_CARRY
      |-> rsp_o.result == {req_i.carry_in, a[31:1]}
       && rsp_o.carry == a[0];
  endproperty
  a_rrx: assert property (p_rrx)
    else $error("carry rotate wrong");

  property p_zero_amt;
    op <= OP_ROTATE_RIGHT && n == 0
      |-> rsp_o.result == a && rsp_o.carry == req_i.carry_in;
  endproperty
  a_zero_amt: assert property (p_zero_amt)
    else $error("zero shift altered operand");

  property p_add;
    op == OP_ADD
      |-> {rsp_o.carry, rsp_o.result} == {1'b0, a} + {1'b0, b}
        + 33'(req_i.carry_in);
  endproperty
  a_add: assert property (p_add)
    else $error("add sum or carry wrong");

  property p_ovf;
    op == OP_ADD |-> rsp_o.overflow == ($signed({a[31], a})
      + $signed({b[31], b}) + $signed({32'h0, req_i.carry_in})
      != $signed({rsp_o.result[31], rsp_o.result}));
  endproperty
  a_ovf: assert property (p_ovf)
    else $error("overflow flag wrong");

  property p_sub;
    op == OP_SUB && req_i.carry_in
      |-> rsp_o.result == a - b && rsp_o.carry == (a >= b);
  endproperty
  a_sub: assert property (p_sub)
    else $error("subtract wrong");

  property p_sbc;
    op == OP_SUB && !req_i.carry_in
      |-> rsp_o.result == a - b - 32'h1 && rsp_o.carry == (a > b);
  endproperty
  a_sbc: assert property (p_sbc)
    else $error("subtract with borrow wrong");

  property p_sat;
    op == OP_SAT_SIGNED && n == 8
      |-> rsp_o.saturated == ($signed(a) > 127 || $signed(a) < -128)
       && (!rsp_o.saturated || rsp_o.result == 32'h7f
           || rsp_o.result == 32'hffffff80);
  endproperty
  a_sat: assert property (p_sat)
    else $error("saturation wrong");

  property p_comb;
    $stable(req_i) |-> $stable(rsp_o);
  endproperty
  a_comb: assert property (p_comb)
    else $error("answer moved without request change");

endmodule : shad_datapath

// *** testbench/shad_exec_model.sv ***
// Execute control model that presents requests to the datapath
`timescale 1ns/1ps
module shad_exec_model
  import shad_pkg::*;
(
  // Clock
  input  wire logic clk_sys_i,
  // Request to the datapath
  output shad_req_s req_o
);
  initial req_o = '0;

  // ==========================================================
  // New request lands just after the falling edge
  task automatic issue(input shad_req_s r);
    @(negedge clk_sys_i);
    req_o = r;
  endtask : issue
endmodule : shad_exec_model

// *** testbench/testbench.sv ***
// Self-checking bench of the shift and add datapath
`timescale 1ns/1ps
module testbench
  import shad_pkg::*;
;
  logic      clk_sys_i;
  logic      reset_i;
  shad_req_s req;
  shad_rsp_s rsp;
  shad_req_s r;
  shad_rsp_s e;
  int        mismatches;
  int        n_compared;
  longint    d;
  logic [31:0] vals [6] = '{32'h0, 32'h1, 32'h7fffffff, 32'h80000000,
                            32'hffffffff, 32'h5a3c0f96};
  logic [7:0]  amts [7] = '{8'h0, 8'h1, 8'h8, 8'h1f, 8'h20, 8'h21, 8'hff};

  shad_exec_model i_shad_exec_model (
    .clk_sys_i (clk_sys_i),
    .req_o     (req)
  );

  shad_datapath i_shad_datapath (
    .clk_sys_i (clk_sys_i),
    .reset_i   (reset_i),
    .req_i     (req),
    .rsp_o     (rsp)
  );

  // ==========================================================
  // Reference model
  function automatic shad_sum_s add_pass(input logic [31:0] x,
                                         input logic [31:0] y,
                                         input logic        c);
    logic [32:0] s;
    shad_sum_s   o;
    s = {1'b0, x} + {1'b0, y} + {32'h0, c};
    o.sum = s[31:0];
    o.carry = s[32];
    o.overflow = longint'($signed(x)) + longint'($signed(y)) + longint'(c)
                 != longint'($signed(s[31:0]));
    return o;
  endfunction : add_pass

  function automatic shad_rsp_s exp_rsp(input shad_req_s q);
    shad_rsp_s          x;
    shad_sum_s          lo;
    shad_sum_s          hi;
    logic [63:0]        u;
    logic signed [63:0] s;
    logic [31:0]        yb;
    logic [31:0]        yh;
    longint             v;
    longint             mx;
    longint             mn;
    int                 n;
    x = '0;
    x.result = q.opa;
    x.carry = q.carry_in;
    yb = (q.op inside {OP_SUB, OP_SUB_PAIR}) ? ~q.opb : q.opb;
    yh = (q.op == OP_SUB_PAIR) ? ~q.opb_hi : q.opb_hi;
    n = (q.amount == 8'h0 || q.amount > 8'h20) ? 32 : int'(q.amount);
    v = longint'($signed(q.opa));
    case (q.op)
      OP_LOGICAL_SHIFT_LEFT: begin
        u = {32'h0, q.opa} << q.amount;
        if (q.amount != 8'h0) {x.carry, x.result} = u[32:0];
      end
      OP_LOGICAL_SHIFT_RIGHT: begin
        u = {q.opa, 32'h0} >> q.amount;
        if (q.amount != 8'h0) {x.result, x.carry} = u[63:31];
      end
      OP_ARITHMETIC_SHIFT_RIGHT: begin
        s = $signed({q.opa, 32'h0}) >>> q.amount;
        if (q.amount != 8'h0) {x.result, x.carry} = s[63:31];
      end
      OP_ROTATE_RIGHT: if (q.amount != 8'h0) begin
        x.result = (q.opa >> q.amount[4:0]) |
                   (q.opa << (6'h20 - q.amount[4:0]));
        x.carry = x.result[31];
      end
      OP_ROTATE_THROUGH_CARRY: begin
        x.result = {q.carry_in, q.opa[31:1]};
        x.carry = q.opa[0];
      end
      OP_ADD, OP_SUB: begin
        lo = add_pass(q.opa, yb, q.carry_in);
        {x.result, x.carry, x.overflow} = lo;
      end
      OP_ADD_PAIR, OP_SUB_PAIR: begin
        lo = add_pass(q.opa, yb, q.carry_in);
        hi = add_pass(q.opa_hi, yh, lo.carry);
        x.result = lo.sum;
        {x.result_hi, x.carry, x.overflow} = hi;
      end
      OP_LOAD_EXTEND: case (q.load_size)
        SIZE_BYTE: x.result = {{24{q.load_signed & q.opa[7]}}, q.opa[7:0]};
        SIZE_HALF: x.result = {{16{q.load_signed & q.opa[15]}}, q.opa[15:0]};
        default: ;
      endcase
      OP_SAT_SIGNED, OP_SAT_UNSIGNED: begin
        mx = (q.op == OP_SAT_SIGNED) ? (longint'(1) <<< (n - 1)) - 1
                                     : (longint'(1) <<< n) - 1;
        mn = (q.op == OP_SAT_SIGNED) ? -(longint'(1) <<< (n - 1)) : 0;
        x.saturated = (v > mx) || (v < mn);
        x.result = 32'(v > mx ? mx : (v < mn ? mn : v));
      end
      default: ;
    endcase
    return x;
  endfunction : exp_rsp

  // ==========================================================
  // Checking and verdict
  task automatic check(input shad_rsp_s seen, input shad_rsp_s exp);
    n_compared++;
    if (seen !== exp) begin
      mismatches++;
      $display("[ERR] %0t rsp %h expected %h", $time, seen, exp);
    end
  endtask : check

  task automatic give_verdict();
    $display("compared %0d mismatches %0d", n_compared, mismatches);
    if (mismatches == 0 && n_compared > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask : give_verdict

  // Answer is looked at inside the cycle the request is presented
  task automatic try_req(input shad_req_s q);
    i_shad_exec_model.issue(q);
    #1;
    case (q.op)
      OP_LOGICAL_SHIFT_LEFT: check(rsp, exp_rsp(q));
      OP_LOGICAL_SHIFT_RIGHT: check(rsp, exp_rsp(q));
      OP_ARITHMETIC_SHIFT_RIGHT: check(rsp, exp_rsp(q));
      OP_ROTATE_RIGHT: check(rsp, exp_rsp(q));
      OP_ROTATE_THROUGH_CARRY: check(rsp, exp_rsp(q));
      OP_ADD, OP_SUB: check(rsp, exp_rsp(q));
      OP_ADD_PAIR, OP_SUB_PAIR: check(rsp, exp_rsp(q));
      OP_LOAD_EXTEND: check(rsp, exp_rsp(q));
      OP_SAT_SIGNED, OP_SAT_UNSIGNED: check(rsp, exp_rsp(q));
      default: check(rsp, exp_rsp(q));
    endcase
  endtask : try_req

  // ==========================================================
  // Clock, reset and tests
  initial begin
    clk_sys_i = 1'b0;
    forever #5 clk_sys_i = ~clk_sys_i;
  end

  initial begin
    reset_i = 1'b1;
    mismatches = 0;
    n_compared = 0;
    void'($urandom(32'h245a));
    repeat (3) @(negedge clk_sys_i);
    reset_i = 1'b0;
    // Every op code against boundary operands and amounts
    for (int op = 0; op < 16; op++) begin
      for (int a = 0; a < 6; a++) begin
        for (int m = 0; m < 7; m++) begin
          r = '0;
          r.op = shad_op_e'(4'(op));
          r.opa = vals[a];
          r.opb = vals[5 - a];
          r.opa_hi = vals[(a + 1) % 6];
          r.opb_hi = vals[(a + 3) % 6];
          r.amount = amts[m];
          r.carry_in = m[0];
          r.load_size = shad_size_e'(2'(m % 3));
          r.load_signed = a[0];
          try_req(r);
        end
      end
    end
    $display("test corners done");
    // Back-to-back random requests with a reset pulse among them
    for (int i = 0; i < 2000; i++) begin
      r.op = shad_op_e'(4'($urandom_range(0, 15)));
      r.opa = $urandom;
      r.opb = $urandom;
      r.opa_hi = $urandom;
      r.opb_hi = $urandom;
      r.amount = (i % 8 == 0) ? 8'($urandom) : 8'($urandom_range(0, 40));
      r.carry_in = 1'($urandom);
      r.load_size = shad_size_e'(2'($urandom_range(0, 2)));
      r.load_signed = 1'($urandom);
      try_req(r);
      reset_i = (i >= 1000 && i < 1004);
    end
    $display("test random done");
    // Subtraction borrow, equal operands included
    for (int i = 0; i < 300; i++) begin
      r = '0;
      r.op = OP_SUB;
      r.opa = $urandom;
      r.opb = (i % 4 == 0) ? r.opa : 32'($urandom);
      r.carry_in = i[0];
      e = '0;
      e.result = r.opa - r.opb - {31'h0, ~r.carry_in};
      e.carry = r.carry_in ? (r.opa >= r.opb) : (r.opa > r.opb);
      d = longint'($signed(r.opa)) - longint'($signed(r.opb)) -
          longint'(!r.carry_in);
      e.overflow = (d > 64'sh7fffffff) || (d < -64'sh80000000);
      i_shad_exec_model.issue(r);
      #1;
      check(rsp, e);
    end
    $display("test subtract done");
    give_verdict();
  end

  initial begin
    #500us;
    mismatches++;
    $display("[ERR] %0t watchdog expired", $time);
    give_verdict();
  end
endmodule : testbench
